// file: design/lockfuse_access.sv
// Parallel-programming lock bit, fuse status and signature access logic
`timescale 1ns/1ps
`default_nettype none
module lockfuse_access (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RESETN,
  // Programmer strobes and controls (pins, active low where named _N)
  input wire logic OSC_INPUT_PIN,
  input wire logic WR_N,
  input wire logic OE_N,
  input wire logic BYTE_SELECT,
  input wire logic XA_CMD,
  input wire logic XA_ADDR,
  input wire logic XA_DATA,
  input wire logic CHIP_ERASE,
  // Data bus
  input wire logic [7:0] DATA_IN,
  output logic [7:0] DATA_OUT,
  output logic DATA_OE,
  // Status
  input wire logic SERIAL_PROGRAM_ENABLE_FUSE,
  output logic READY_BUSY_FLAG,
  output logic [1:0] LOCK_BITS
);
  logic [1:0] osc_s_reg, wr_s_reg, oe_s_reg, bs_s_reg, xc_s_reg, xa_s_reg, xd_s_reg, ce_s_reg, sp_s_reg;
  logic [7:0] din_s1_reg, din_s2_reg;
  logic osc_d_reg, wr_d_reg;
  logic [7:0] cmd_reg, data_reg, addr_reg;
  logic [1:0] lock_reg;
  logic [14:0] busy_cnt_reg;
  lockfuse_pkg::prog_state_t state_reg;
  logic [7:0] sig_rdata;
  logic osc_rise, wr_fall, oe_low, bs;

  // Two-stage synchronisers for all pin inputs
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_s_reg <= 2'h0;
      wr_s_reg <= 2'h3;
      oe_s_reg <= 2'h3;
      bs_s_reg <= 2'h0;
      xc_s_reg <= 2'h0;
      xa_s_reg <= 2'h0;
      xd_s_reg <= 2'h0;
      ce_s_reg <= 2'h0;
      sp_s_reg <= 2'h0;
      din_s1_reg <= 8'h00;
      din_s2_reg <= 8'h00;
    end else begin
      osc_s_reg <= {osc_s_reg[0], OSC_INPUT_PIN};
      wr_s_reg <= {wr_s_reg[0], WR_N};
      oe_s_reg <= {oe_s_reg[0], OE_N};
      bs_s_reg <= {bs_s_reg[0], BYTE_SELECT};
      xc_s_reg <= {xc_s_reg[0], XA_CMD};
      xa_s_reg <= {xa_s_reg[0], XA_ADDR};
      xd_s_reg <= {xd_s_reg[0], XA_DATA};
      ce_s_reg <= {ce_s_reg[0], CHIP_ERASE};
      sp_s_reg <= {sp_s_reg[0], SERIAL_PROGRAM_ENABLE_FUSE};
      din_s1_reg <= DATA_IN;
      din_s2_reg <= din_s1_reg;
    end
  end

  // Edge history on synchronised levels only
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      osc_d_reg <= 1'b0;
      wr_d_reg <= 1'b1;
    end else begin
      osc_d_reg <= osc_s_reg[1];
      wr_d_reg <= wr_s_reg[1];
    end
  end

  assign osc_rise = osc_s_reg[1] & ~osc_d_reg;
  assign wr_fall = ~wr_s_reg[1] & wr_d_reg;
  assign oe_low = ~oe_s_reg[1];
  assign bs = bs_s_reg[1];

  // Command, address and data latches on the oscillator pin pulse
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      cmd_reg <= lockfuse_pkg::CMD_RESET;
      addr_reg <= 8'h00;
      data_reg <= lockfuse_pkg::DATA_RESET;
    end else if (osc_rise) begin
      if (xc_s_reg[1]) begin
        cmd_reg <= din_s2_reg;
      end else if (xa_s_reg[1]) begin
        addr_reg <= din_s2_reg;
      end else if (xd_s_reg[1]) begin
        data_reg <= din_s2_reg;
      end
    end
  end

  // Lock storage: bits only ever clear, except by chip erase
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lock_reg <= lockfuse_pkg::LOCK_RESET;
    end else if (wr_fall && ce_s_reg[1]) begin
      lock_reg <= lockfuse_pkg::LOCK_RESET;
    end else if (wr_fall && cmd_reg == lockfuse_pkg::CMD_WRITE_LOCK) begin
      lock_reg <= lock_reg & {data_reg[lockfuse_pkg::LOCK_DATA_LB2_POS],
                              data_reg[lockfuse_pkg::LOCK_DATA_LB1_POS]};
    end
  end

  // Busy timer; fuse writes use other commands and never start it
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= lockfuse_pkg::ST_IDLE;
      busy_cnt_reg <= 15'h0000;
    end else begin
      case (state_reg)
        lockfuse_pkg::ST_IDLE: begin
          if (wr_fall && cmd_reg == lockfuse_pkg::CMD_WRITE_LOCK && !ce_s_reg[1]) begin
            state_reg <= lockfuse_pkg::ST_BUSY;
            busy_cnt_reg <= 15'(lockfuse_pkg::BUSY_CYCLES - 1);
          end
        end
        default: begin
          if (busy_cnt_reg == 15'h0000) begin
            state_reg <= lockfuse_pkg::ST_IDLE;
          end else begin
            busy_cnt_reg <= busy_cnt_reg - 15'h0001;
          end
        end
      endcase
    end
  end

  sig_rom u_sig (
    .clk(CORE_CLK),
    .rst_n(RESETN),
    .addr(addr_reg[1:0]),
    .rdata(sig_rdata)
  );

  // Read path; bus released whenever output enable is high
  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end else if (!oe_low) begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end else if (cmd_reg == lockfuse_pkg::CMD_READ_STATUS && bs) begin
      DATA_OUT <= {lock_reg[0], lock_reg[1], sp_s_reg[1], 5'h1f};
      DATA_OE <= 1'b1;
    end else if (cmd_reg == lockfuse_pkg::CMD_READ_SIG && !bs) begin
      DATA_OUT <= (addr_reg <= {6'h00, lockfuse_pkg::SIG_LAST_ADDR}) ? sig_rdata : 8'hff;
      DATA_OE <= 1'b1;
    end else begin
      DATA_OUT <= 8'h00;
      DATA_OE <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESETN) begin
    if (!RESETN) begin
      READY_BUSY_FLAG <= 1'b1;
      LOCK_BITS <= lockfuse_pkg::LOCK_RESET;
    end else begin
      READY_BUSY_FLAG <= (state_reg == lockfuse_pkg::ST_IDLE);
      LOCK_BITS <= lock_reg;
    end
  end

  // Lock bits never rise except on chip erase
  lock_mono_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (|(lock_reg & ~$past(lock_reg))) |-> $past(wr_fall && ce_s_reg[1])) else $error("lock bit rose without erase");
  // Busy starts after lock write strobe
  busy_start_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_fall && cmd_reg == lockfuse_pkg::CMD_WRITE_LOCK && !ce_s_reg[1] && state_reg == lockfuse_pkg::ST_IDLE)
    |-> ##2 !READY_BUSY_FLAG) else $error("ready/busy did not fall");
  // Busy counter bounded
  busy_cnt_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    busy_cnt_reg < 15'(lockfuse_pkg::BUSY_CYCLES)) else $error("busy count out of range");
  // Other commands never drop ready
  fuse_idle_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (state_reg == lockfuse_pkg::ST_IDLE && cmd_reg != lockfuse_pkg::CMD_WRITE_LOCK) |=> state_reg == lockfuse_pkg::ST_IDLE)
    else $error("busy without lock command");
  // Bus released one cycle after output enable rises
  bus_release_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !oe_low |=> !DATA_OE) else $error("bus driven with enable high");
  // Status byte contents
  status_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (oe_low && bs && cmd_reg == lockfuse_pkg::CMD_READ_STATUS) |=> (DATA_OE && DATA_OUT[7:6] == {$past(lock_reg[0]), $past(lock_reg[1])}))
    else $error("status byte wrong");
  // Signature read drives bus
  sig_read_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (oe_low && !bs && cmd_reg == lockfuse_pkg::CMD_READ_SIG) |=> DATA_OE) else $error("signature not driven");
  // Byte select low gives no status
  status_bs_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (!bs && cmd_reg == lockfuse_pkg::CMD_READ_STATUS) |=> !DATA_OE) else $error("status with byte select low");
  // Strobes under any other command, fuse writes among them, leave ready high
  fuse_ready_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (wr_fall && cmd_reg != lockfuse_pkg::CMD_WRITE_LOCK && state_reg == lockfuse_pkg::ST_IDLE)
    |-> ##2 READY_BUSY_FLAG) else $error("ready fell on non-lock strobe");
  // Addresses past the last signature byte read all ones
  sig_range_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    (oe_low && !bs && cmd_reg == lockfuse_pkg::CMD_READ_SIG && addr_reg > {6'h00, lockfuse_pkg::SIG_LAST_ADDR})
    |=> DATA_OUT == 8'hff) else $error("signature out of range not ones");
  // Command only changes on a command latch pulse
  cmd_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RESETN)
    !(osc_rise && xc_s_reg[1]) |=> $stable(cmd_reg)) else $error("command changed without load");
endmodule // lockfuse_access
`default_nettype wire

// file: design/lockfuse_pkg.sv
// Package with commands, field positions, reset values and timing counts for the lock/fuse/signature access block
`default_nettype none
package lockfuse_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  // Commands loaded through the command-load step
  localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
  localparam logic [7:0] CMD_READ_STATUS = 8'h04;
  localparam logic [7:0] CMD_READ_SIG = 8'h08;
  localparam logic [7:0] CMD_RESET = 8'h00;
  // Lock data byte field positions
  localparam int LOCK_DATA_LB2_POS = 2;
  localparam int LOCK_DATA_LB1_POS = 1;
  // Status byte field positions
  localparam int STAT_LB1_POS = 7;
  localparam int STAT_LB2_POS = 6;
  localparam int STAT_SERIAL_PROGRAM_ENABLE_FUSE_POS = 5;
  // Unprogrammed state of lock bits
  localparam logic [1:0] LOCK_RESET = 2'h3;
  localparam logic [7:0] DATA_RESET = 8'hff;
  localparam logic [1:0] SIG_LAST_ADDR = 2'h2;
  // Busy time after a programming strobe, typical figure in microseconds
  localparam int unsigned BUSY_TIME_US = 700;
  localparam int unsigned BUSY_CYCLES = BUSY_TIME_US * (CLK_HZ / 1000000);
  localparam int BUSY_CNT_W = 15;
  typedef enum logic [1:0] {ST_IDLE, ST_BUSY} prog_state_t;
endpackage
`default_nettype wire

// file: design/sig_rom.sv
// Three-word signature store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sig_rom (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] addr,
  output logic [7:0] rdata
);
  // Contents are arbitrary identity values
  localparam logic [7:0] SIG0 = 8'h5a;
  localparam logic [7:0] SIG1 = 8'h11;
  localparam logic [7:0] SIG2 = 8'h22;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (addr == 2'h0) begin
      rdata <= SIG0;
    end else if (addr == 2'h1) begin
      rdata <= SIG1;
    end else if (addr == 2'h2) begin
      rdata <= SIG2;
    end else begin
      rdata <= 8'hff;
    end
  end
endmodule // sig_rom
`default_nettype wire

// file: dv/lockfuse_access_test.sv
// Self-checking testbench for the lock, fuse status and signature block
`timescale 1ns/1ps
`default_nettype none
module lockfuse_access_test;
  logic core_clk, resetn, fuse, osc_pin, wr_n, oe_n, byte_sel, xa_cmd, xa_addr, xa_data, erase;
  logic data_oe, ready;
  logic [7:0] data_in, data_out;
  logic [1:0] lock_bits;
  logic [7:0] exp_q[$];
  logic [7:0] sig_tab[3] = '{8'h5a, 8'h11, 8'h22};
  int errors = 0;
  int samples_checked = 0;
  int n;
  prog_model #(.ERASE_LOW(4000), .FUSE_LOW(2000)) i_prog_model (.clk(core_clk), .osc_pin(osc_pin),
    .wr_n(wr_n), .oe_n(oe_n), .byte_sel(byte_sel), .xa_cmd(xa_cmd), .xa_addr(xa_addr), .xa_data(xa_data),
    .erase(erase), .data(data_in));
  lockfuse_access i_lockfuse_access (.CORE_CLK(core_clk), .RESETN(resetn), .OSC_INPUT_PIN(osc_pin),
    .WR_N(wr_n), .OE_N(oe_n), .BYTE_SELECT(byte_sel), .XA_CMD(xa_cmd), .XA_ADDR(xa_addr), .XA_DATA(xa_data),
    .CHIP_ERASE(erase), .DATA_IN(data_in), .DATA_OUT(data_out), .DATA_OE(data_oe),
    .SERIAL_PROGRAM_ENABLE_FUSE(fuse), .READY_BUSY_FLAG(ready), .LOCK_BITS(lock_bits));
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task check1(input string what, input logic exp, input logic got);
    check8(what, {7'h0, exp}, {7'h0, got});
  endtask
  task test_done;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Each bus drive by the block takes the oldest noted byte
  always @(posedge data_oe) begin
    @(negedge core_clk);
    if (exp_q.size() == 0) begin
      check1("unexpected read", 1'b0, 1'b1);
    end else begin
      check8("data_out", exp_q.pop_front(), data_out);
    end
  end
  // Two busy spans of about 28000 cycles and the short strobes fit well inside this limit
  initial begin
    repeat (90000) @(posedge core_clk);
    errors++;
    test_done;
  end
  task lock_write(input logic [7:0] b, input logic [1:0] exp_lock);
    i_prog_model.load(3'b100, lockfuse_pkg::CMD_WRITE_LOCK);
    i_prog_model.load(3'b001, b);
    i_prog_model.strobe(1'b0);
    check1("busy", 1'b0, ready);
    check8("lock", {6'h0, exp_lock}, {6'h0, lock_bits});
    n = 6;
    while (ready !== 1'b1 && n < 40000) begin
      @(negedge core_clk);
      n++;
    end
    check1("busy span", 1'b1, n >= 20000 && n <= 36000);
  endtask
  task status_read(input logic [1:0] lk);
    fuse = 1'($urandom);
    exp_q.push_back({lk[0], lk[1], fuse, 5'h1f});
    i_prog_model.read(1'b1);
    check1("bus released", 1'b0, data_oe);
  endtask
  initial begin
    resetn = 1'b0;
    fuse = 1'b1;
    void'($urandom(28));
    repeat (20) @(negedge core_clk);
    resetn = 1'b1;
    repeat (2) @(negedge core_clk);
    check8("lock reset", 8'h03, {6'h0, lock_bits});
    lock_write(8'hfb, 2'b01);
    i_prog_model.load(3'b100, lockfuse_pkg::CMD_READ_STATUS);
    status_read(2'b01);
    status_read(2'b01);
    lock_write(8'hfd, 2'b00);
    i_prog_model.load(3'b100, lockfuse_pkg::CMD_READ_SIG);
    for (int a = 3; a >= 0; a--) begin
      i_prog_model.load(3'b010, 8'(a));
      exp_q.push_back(a < 3 ? sig_tab[a] : 8'hff);
      i_prog_model.read(1'b0);
      check1("bus released", 1'b0, data_oe);
    end
    // Any command but lock write stands in for fuse programming here
    i_prog_model.load(3'b100, 8'h80);
    i_prog_model.fuse_strobe;
    check1("fuse ready", 1'b1, ready);
    check8("lock kept", 8'h00, {6'h0, lock_bits});
    i_prog_model.strobe(1'b1);
    check1("erase ready", 1'b1, ready);
    check8("lock erased", 8'h03, {6'h0, lock_bits});
    i_prog_model.load(3'b100, lockfuse_pkg::CMD_READ_STATUS);
    status_read(2'b11);
    check8("reads left", 8'h0, 8'(exp_q.size()));
    test_done;
  end
endmodule // lockfuse_access_test
`default_nettype wire

// file: dv/prog_model.sv
// Parallel programmer model for the lock, fuse and signature pins
`timescale 1ns/1ps
`default_nettype none
module prog_model #(
  parameter int ERASE_LOW = 400000,
  parameter int FUSE_LOW = 60000
) (
  // Clock
  input wire logic clk,
  // Strobes and selects
  output logic osc_pin,
  output logic wr_n,
  output logic oe_n,
  output logic byte_sel,
  output logic xa_cmd,
  output logic xa_addr,
  output logic xa_data,
  output logic erase,
  // Bus toward the block
  output logic [7:0] data
);
  initial begin
    {osc_pin, wr_n, oe_n, byte_sel} = 4'h6;
    {xa_cmd, xa_addr, xa_data, erase} = 4'h0;
    data = 8'hff;
  end
  task wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Setup, high time and hold of 75 ns are three cycles each
  task load(input logic [2:0] sel, input logic [7:0] b);
    {xa_cmd, xa_addr, xa_data} = sel;
    data = b;
    wait_n(3);
    osc_pin = 1'b1;
    wait_n(3);
    osc_pin = 1'b0;
    wait_n(3);
    {xa_cmd, xa_addr, xa_data} = 3'h0;
    data = ~b;
    wait_n(4);
  endtask
  // Erase width is a parameter so a run stays short; the block acts on the falling edge
  task strobe(input logic ce);
    erase = ce;
    wait_n(3);
    wr_n = 1'b0;
    wait_n(ce ? ERASE_LOW : 3);
    wr_n = 1'b1;
    wait_n(3);
    erase = 1'b0;
  endtask
  // Fuse strobe width is shortened by parameter as well; the block must show no busy for it
  task fuse_strobe;
    wr_n = 1'b0;
    wait_n(FUSE_LOW);
    wr_n = 1'b1;
    wait_n(3);
  endtask
  // Bus is released while the block drives, so the old byte is inverted
  task read(input logic bs);
    byte_sel = bs;
    data = ~data;
    wait_n(3);
    oe_n = 1'b0;
    wait_n(8);
    oe_n = 1'b1;
    wait_n(6);
  endtask
endmodule // prog_model
`default_nettype wire
